// *** rtl/scn_pkg.sv ***
// Purpose: Shared constants and state types of the scanner request link
// Assumes: One 125 MHz core clock, byte-wide link between the two ends
// Notes: Times are kept in their own unit; cycle counts derive from them
package scn_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam logic [7:0] REQ_START = 8'hA5;
   localparam logic [7:0] DESC_SYNC1 = 8'hA5;
   localparam logic [7:0] DESC_SYNC2 = 8'h5A;
   localparam logic [7:0] CMD_STOP = 8'h25;
   localparam logic [7:0] CMD_CORE_RESET = 8'h40;
   localparam int PAYLOAD_FLAG_BIT = 7;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_MULTI = 2'h1;
   localparam logic [2:0] DESC_LAST_IDX = 3'h6;
   localparam logic [1:0] LEN_LAST_IDX = 2'h3;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int REQ_TIMEOUT_S = 5;
   localparam int REQ_TIMEOUT_CYCLES = REQ_TIMEOUT_S * CLK_HZ;
   localparam int STOP_GAP_US = 1000;
   localparam int STOP_GAP_CYCLES = STOP_GAP_US * (CLK_HZ / 1_000_000);
   localparam int RESET_GAP_US = 2000;
   localparam int RESET_GAP_CYCLES = RESET_GAP_US * (CLK_HZ / 1_000_000);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_CNT = 3'b010,
      ST_PLD = 3'b011,
      ST_SUM = 3'b100,
      ST_WAIT = 3'b101,
      ST_DESC = 3'b110,
      ST_DATA = 3'b111
   } scn_dev_state_type;

   typedef enum logic [2:0] {
      HT_IDLE = 3'b000,
      HT_START = 3'b001,
      HT_CMD = 3'b010,
      HT_CNT = 3'b011,
      HT_PLD = 3'b100,
      HT_SUM = 3'b101,
      HT_GAP = 3'b110,
      HT_AWAIT = 3'b111
   } scn_htx_state_type;

   typedef enum logic [2:0] {
      HR_HUNT = 3'b000,
      HR_SYNC = 3'b001,
      HR_LEN = 3'b010,
      HR_TYPE = 3'b011,
      HR_DATA = 3'b100
   } scn_hrx_state_type;

   typedef struct packed {
      scn_dev_state_type st;
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [7:0] left;
      logic [7:0] sum;
      logic [29:0] len;
      logic [1:0] mode;
      logic [7:0] dtype;
      logic [29:0] bcnt;
      logic [2:0] didx;
      logic [29:0] tmo;
      logic [7:0] tx_data;
      logic tx_valid;
      logic cmd_valid;
      logic [7:0] pld;
      logic pld_valid;
      logic err;
   } scn_dev_reg_type;

   typedef struct packed {
      scn_htx_state_type tst;
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [7:0] left;
      logic [7:0] sum;
      logic [7:0] tx_data;
      logic tx_valid;
      logic [29:0] wait_cnt;
      logic [29:0] wait_lim;
      scn_hrx_state_type rst;
      logic [1:0] ridx;
      logic [31:0] word;
      logic [29:0] rlen;
      logic [1:0] rmode;
      logic [29:0] rcnt;
      logic desc_valid;
      logic [7:0] dtype;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic rx_last;
   } scn_host_reg_type;

   localparam scn_dev_reg_type DEV_RESET = '0;
   localparam scn_host_reg_type HOST_RESET = '0;
endpackage

// *** rtl/scn_link_if.sv ***
// Purpose: Byte link between host controller and scanner protocol engine
// Assumes: Both ends on the same core clock; valid/ready per byte
// Notes: Serial framing below byte level is outside this link
`timescale 1ns/100ps
interface scn_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;

   modport dev (
      input h2d_data,
      input h2d_valid,
      output h2d_ready,
      output d2h_data,
      output d2h_valid,
      input d2h_ready
   );

   modport host (
      output h2d_data,
      output h2d_valid,
      input h2d_ready,
      input d2h_data,
      input d2h_valid,
      output d2h_ready
   );
endinterface

// *** rtl/scn_device.sv ***
// Purpose: Scanner end of the request/response link: parses requests,
//          frames descriptors and data responses
// Assumes: User logic answers each accepted command with start or none
// Notes: Incoming bytes pass a FIFO so requests during streaming wait
//
// Function
// [R1] Transmit nothing until a request arrives
// [R2] Byte A5 starts every request
// [R3] One command byte follows the start
// [R4] Payload requests carry count, payload, checksum
// [R5] Checksum is XOR of all prior bytes
// [R6] Multi-byte fields go low byte first
// [R7] Drop partial request after five seconds
// [R8] Host waits for answer before next request
// [R9] Drop requests while busy outside streaming
// [R10] Streaming repeats one data packet per sample
// [R11] Any request ends streaming, then gets handled
// [R12] Requests during streaming are buffered, run later
// [R13] Stop and core reset send no reply
// [R14] Host pauses after a no-reply command
// [R15] One descriptor, then data packets, per session
// [R16] Descriptor opens with A5 then 5A
// [R17] Descriptor: 30-bit length, 2-bit mode, type
// [R18] Mode 0 single, 1 continuous, others reserved
// [R19] All data packets share advertised length
// [R20] Data type matches the accepted request
// [R21] Length and mode form one 32-bit word
// [R22] Idle ignores bytes other than A5
// [R23] Stop is A5 25, returns to idle
// [R24] Host waits 1 ms after stop, 2 ms reset
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Byte FIFO
module scn_fifo #(
   parameter int WIDTH = scn_pkg::FIFO_WIDTH,
   parameter int DEPTH = scn_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } scn_fifo_ptr_type;

   logic [WIDTH-1:0] mem [DEPTH];
   scn_fifo_ptr_type r;
   scn_fifo_ptr_type next_r;
   logic full;
   logic empty;

   assign full = (r.wptr[AW] != r.rptr[AW]) && (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
   assign empty = (r.wptr == r.rptr);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[r.rptr[AW-1:0]];

   always_comb
   begin
      next_r = r;
      if (in_valid_i && !full)
      begin
         next_r.wptr = r.wptr + (AW+1)'(1);
      end
      if (out_ready_i && !empty)
      begin
         next_r.rptr = r.rptr + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (in_valid_i && !full)
      begin
         mem[r.wptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Device end
module scn_device #(
   parameter int TIMEOUT_CYCLES = scn_pkg::REQ_TIMEOUT_CYCLES,
   parameter int FIFO_DEPTH = scn_pkg::FIFO_DEPTH
) (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   scn_link_if.dev LINK,
   output logic CMD_VALID_O,
   output logic [7:0] CMD_CODE_O,
   output logic [7:0] PLD_COUNT_O,
   output logic PLD_VALID_O,
   output logic [7:0] PLD_BYTE_O,
   output logic REQ_ERR_O,
   input wire logic RSP_START_I,
   input wire logic RSP_NONE_I,
   input wire logic [29:0] RSP_LEN_I,
   input wire logic [1:0] RSP_MODE_I,
   input wire logic [7:0] RSP_TYPE_I,
   input wire logic DATA_VALID_I,
   input wire logic [7:0] DATA_BYTE_I,
   output logic DATA_READY_O,
   output logic SCAN_ACTIVE_O
);
   scn_pkg::scn_dev_reg_type r;
   scn_pkg::scn_dev_reg_type next_r;
   logic fv;
   logic [7:0] fb;
   logic pop;
   logic multi;
   logic parsing;

   // Descriptor byte by index, length and mode packed low byte first
   function automatic logic [7:0] desc_byte(input logic [2:0] idx, input logic [29:0] len,
                                            input logic [1:0] mode, input logic [7:0] dtype);
      logic [31:0] word;
      word = {mode, len}; // R21 R17
      unique case (idx)
         3'h0: desc_byte = scn_pkg::DESC_SYNC1; // R16
         3'h1: desc_byte = scn_pkg::DESC_SYNC2; // R16
         3'h2: desc_byte = word[7:0]; // R6
         3'h3: desc_byte = word[15:8];
         3'h4: desc_byte = word[23:16];
         3'h5: desc_byte = word[31:24];
         default: desc_byte = dtype; // R20
      endcase
   endfunction

   scn_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(CORE_CLK_I),
      .resetn_i(RESETN_I),
      .in_valid_i(LINK.h2d_valid),
      .in_ready_o(LINK.h2d_ready),
      .in_data_i(LINK.h2d_data),
      .out_valid_o(fv),
      .out_ready_i(pop),
      .out_data_o(fb)
   );

   assign multi = (r.mode == scn_pkg::MODE_MULTI);
   assign parsing = (r.st == scn_pkg::ST_CMD) || (r.st == scn_pkg::ST_CNT) ||
                    (r.st == scn_pkg::ST_PLD) || (r.st == scn_pkg::ST_SUM);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_r = r;
      pop = 1'b0;
      next_r.cmd_valid = 1'b0;
      next_r.pld_valid = 1'b0;
      next_r.err = 1'b0;
      if (r.tx_valid && LINK.d2h_ready)
      begin
         next_r.tx_valid = 1'b0;
      end
      if (parsing)
      begin
         next_r.tmo = r.tmo + 30'h1;
      end
      unique case (r.st)
         scn_pkg::ST_IDLE:
         begin
            pop = fv; // R22
            if (fv && fb == scn_pkg::REQ_START) // R2
            begin
               next_r.st = scn_pkg::ST_CMD;
               next_r.sum = fb;
               next_r.tmo = '0;
            end
         end
         scn_pkg::ST_CMD:
         begin
            pop = fv;
            if (fv)
            begin
               next_r.cmd = fb; // R3
               next_r.sum = r.sum ^ fb;
               next_r.cnt = '0;
               if (fb[scn_pkg::PAYLOAD_FLAG_BIT]) // R4
               begin
                  next_r.st = scn_pkg::ST_CNT;
               end
               else
               begin
                  next_r.cmd_valid = 1'b1; // R23
                  next_r.st = scn_pkg::ST_WAIT;
               end
            end
         end
         scn_pkg::ST_CNT:
         begin
            pop = fv;
            if (fv)
            begin
               next_r.cnt = fb; // R4
               next_r.left = fb;
               next_r.sum = r.sum ^ fb;
               next_r.st = (fb == 8'h00) ? scn_pkg::ST_SUM : scn_pkg::ST_PLD;
            end
         end
         scn_pkg::ST_PLD:
         begin
            pop = fv;
            if (fv)
            begin
               next_r.pld = fb;
               next_r.pld_valid = 1'b1;
               next_r.sum = r.sum ^ fb;
               next_r.left = r.left - 8'h01;
               if (r.left == 8'h01)
               begin
                  next_r.st = scn_pkg::ST_SUM;
               end
            end
         end
         scn_pkg::ST_SUM:
         begin
            pop = fv;
            if (fv)
            begin
               if (fb == r.sum) // R5
               begin
                  next_r.cmd_valid = 1'b1;
                  next_r.st = scn_pkg::ST_WAIT;
               end
               else
               begin
                  next_r.err = 1'b1;
                  next_r.st = scn_pkg::ST_IDLE;
               end
            end
         end
         scn_pkg::ST_WAIT:
         begin
            pop = fv; // R9
            if (RSP_NONE_I)
            begin
               next_r.st = scn_pkg::ST_IDLE; // R13
            end
            else if (RSP_START_I)
            begin
               next_r.len = RSP_LEN_I;
               next_r.mode = {1'b0, RSP_MODE_I[0]}; // R18
               next_r.dtype = RSP_TYPE_I; // R20
               next_r.didx = '0;
               next_r.st = scn_pkg::ST_DESC;
            end
         end
         scn_pkg::ST_DESC:
         begin
            pop = fv && !multi; // R9 R12
            if (!r.tx_valid) // R15
            begin
               next_r.tx_data = desc_byte(r.didx, r.len, r.mode, r.dtype);
               next_r.tx_valid = 1'b1;
               next_r.didx = r.didx + 3'h1;
               if (r.didx == scn_pkg::DESC_LAST_IDX)
               begin
                  next_r.bcnt = '0;
                  next_r.st = (r.len == '0) ? scn_pkg::ST_IDLE : scn_pkg::ST_DATA;
               end
            end
         end
         scn_pkg::ST_DATA:
         begin
            pop = fv && !multi; // R9 R12
            if (multi && fv && r.bcnt == '0)
            begin
               next_r.st = scn_pkg::ST_IDLE; // R11
            end
            else if (!r.tx_valid && DATA_VALID_I)
            begin
               next_r.tx_data = DATA_BYTE_I; // R10
               next_r.tx_valid = 1'b1;
               next_r.bcnt = r.bcnt + 30'h1;
               if (r.bcnt == r.len - 30'h1) // R19
               begin
                  next_r.bcnt = '0;
                  if (!multi || fv) // R11 R12
                  begin
                     next_r.st = scn_pkg::ST_IDLE;
                  end
               end
            end
         end
      endcase
      if (parsing && r.tmo == 30'(TIMEOUT_CYCLES - 1)) // R7
      begin
         next_r.st = scn_pkg::ST_IDLE;
         next_r.err = 1'b1;
         pop = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESETN_I)
      begin
         r <= scn_pkg::DEV_RESET; // R1
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign LINK.d2h_data = r.tx_data;
   assign LINK.d2h_valid = r.tx_valid; // R1
   assign CMD_VALID_O = r.cmd_valid;
   assign CMD_CODE_O = r.cmd;
   assign PLD_COUNT_O = r.cnt;
   assign PLD_VALID_O = r.pld_valid;
   assign PLD_BYTE_O = r.pld;
   assign REQ_ERR_O = r.err;
   assign DATA_READY_O = (r.st == scn_pkg::ST_DATA) && !r.tx_valid &&
                         !(multi && fv && r.bcnt == '0);
   assign SCAN_ACTIVE_O = (r.st == scn_pkg::ST_DATA) && multi;
endmodule

// *** rtl/scn_host.sv ***
// Purpose: Host end of the scanner link: frames requests, paces them,
//          and splits descriptors from data responses
// Assumes: Device end on the same core clock
// Notes: Command codes with the top bit set carry a payload
`timescale 1ns/100ps
module scn_host #(
   parameter int STOP_GAP = scn_pkg::STOP_GAP_CYCLES,
   parameter int RESET_GAP = scn_pkg::RESET_GAP_CYCLES,
   parameter int REPLY_WAIT = scn_pkg::REQ_TIMEOUT_CYCLES
) (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   scn_link_if.host LINK,
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire logic [7:0] REQ_CMD_I,
   input wire logic [7:0] REQ_COUNT_I,
   input wire logic PLD_VALID_I,
   input wire logic [7:0] PLD_BYTE_I,
   output logic PLD_READY_O,
   output logic DESC_VALID_O,
   output logic [29:0] DESC_LEN_O,
   output logic [1:0] DESC_MODE_O,
   output logic [7:0] DESC_TYPE_O,
   output logic RX_VALID_O,
   output logic [7:0] RX_BYTE_O,
   output logic RX_LAST_O
);
   scn_pkg::scn_host_reg_type r;
   scn_pkg::scn_host_reg_type next_r;
   logic free;
   logic [7:0] b;

   assign free = !r.tx_valid || LINK.h2d_ready;
   assign b = LINK.d2h_data;

   ////////////////////////////////////////////////////////////////////////////
   // Request side
   always_comb
   begin
      next_r = r;
      next_r.desc_valid = 1'b0;
      next_r.rx_valid = 1'b0;
      next_r.rx_last = 1'b0;
      if (r.tx_valid && LINK.h2d_ready)
      begin
         next_r.tx_valid = 1'b0;
      end
      unique case (r.tst)
         scn_pkg::HT_IDLE:
         begin
            if (REQ_VALID_I)
            begin
               next_r.cmd = REQ_CMD_I;
               next_r.cnt = REQ_COUNT_I;
               next_r.tst = scn_pkg::HT_START;
               next_r.rst = scn_pkg::HR_HUNT;
            end
         end
         scn_pkg::HT_START:
         begin
            if (free)
            begin
               next_r.tx_data = scn_pkg::REQ_START; // R2
               next_r.tx_valid = 1'b1;
               next_r.sum = scn_pkg::REQ_START;
               next_r.tst = scn_pkg::HT_CMD;
            end
         end
         scn_pkg::HT_CMD:
         begin
            if (free)
            begin
               next_r.tx_data = r.cmd; // R3
               next_r.tx_valid = 1'b1;
               next_r.sum = r.sum ^ r.cmd;
               next_r.wait_cnt = '0;
               if (r.cmd[scn_pkg::PAYLOAD_FLAG_BIT])
               begin
                  next_r.tst = scn_pkg::HT_CNT;
               end
               else if (r.cmd == scn_pkg::CMD_STOP) // R23
               begin
                  next_r.wait_lim = 30'(STOP_GAP); // R24
                  next_r.tst = scn_pkg::HT_GAP;
               end
               else if (r.cmd == scn_pkg::CMD_CORE_RESET)
               begin
                  next_r.wait_lim = 30'(RESET_GAP); // R24
                  next_r.tst = scn_pkg::HT_GAP;
               end
               else
               begin
                  next_r.wait_lim = 30'(REPLY_WAIT);
                  next_r.tst = scn_pkg::HT_AWAIT;
               end
            end
         end
         scn_pkg::HT_CNT:
         begin
            if (free)
            begin
               next_r.tx_data = r.cnt; // R4
               next_r.tx_valid = 1'b1;
               next_r.sum = r.sum ^ r.cnt;
               next_r.left = r.cnt;
               next_r.tst = (r.cnt == 8'h00) ? scn_pkg::HT_SUM : scn_pkg::HT_PLD;
            end
         end
         scn_pkg::HT_PLD:
         begin
            if (free && PLD_VALID_I)
            begin
               next_r.tx_data = PLD_BYTE_I;
               next_r.tx_valid = 1'b1;
               next_r.sum = r.sum ^ PLD_BYTE_I;
               next_r.left = r.left - 8'h01;
               if (r.left == 8'h01)
               begin
                  next_r.tst = scn_pkg::HT_SUM;
               end
            end
         end
         scn_pkg::HT_SUM:
         begin
            if (free)
            begin
               next_r.tx_data = r.sum; // R5
               next_r.tx_valid = 1'b1;
               next_r.wait_cnt = '0;
               next_r.wait_lim = 30'(REPLY_WAIT);
               next_r.tst = scn_pkg::HT_AWAIT;
            end
         end
         scn_pkg::HT_GAP:
         begin
            if (!r.tx_valid) // R14
            begin
               next_r.wait_cnt = r.wait_cnt + 30'h1;
               if (r.wait_cnt == r.wait_lim - 30'h1)
               begin
                  next_r.tst = scn_pkg::HT_IDLE;
               end
            end
         end
         scn_pkg::HT_AWAIT:
         begin
            next_r.wait_cnt = r.wait_cnt + 30'h1; // R8
            if (r.desc_valid || r.wait_cnt == r.wait_lim - 30'h1)
            begin
               next_r.tst = scn_pkg::HT_IDLE;
            end
         end
      endcase

      /////////////////////////////////////////////////////////////////////////
      // Response side
      if (LINK.d2h_valid)
      begin
         unique case (next_r.rst)
            scn_pkg::HR_HUNT:
            begin
               if (b == scn_pkg::DESC_SYNC1) // R16
               begin
                  next_r.rst = scn_pkg::HR_SYNC;
               end
            end
            scn_pkg::HR_SYNC:
            begin
               next_r.ridx = '0;
               if (b == scn_pkg::DESC_SYNC2)
               begin
                  next_r.rst = scn_pkg::HR_LEN;
               end
               else if (b != scn_pkg::DESC_SYNC1)
               begin
                  next_r.rst = scn_pkg::HR_HUNT;
               end
            end
            scn_pkg::HR_LEN:
            begin
               next_r.word[{r.ridx, 3'b000} +: 8] = b; // R6 R21
               next_r.ridx = r.ridx + 2'h1;
               if (r.ridx == scn_pkg::LEN_LAST_IDX)
               begin
                  next_r.rst = scn_pkg::HR_TYPE;
               end
            end
            scn_pkg::HR_TYPE:
            begin
               next_r.desc_valid = 1'b1; // R15 R17
               next_r.rlen = r.word[29:0];
               next_r.rmode = r.word[31:30];
               next_r.dtype = b;
               next_r.rcnt = '0;
               next_r.rst = (r.word[29:0] == '0) ? scn_pkg::HR_HUNT : scn_pkg::HR_DATA;
            end
            scn_pkg::HR_DATA:
            begin
               next_r.rx_valid = 1'b1;
               next_r.rx_byte = b;
               next_r.rcnt = r.rcnt + 30'h1;
               if (r.rcnt == r.rlen - 30'h1) // R19
               begin
                  next_r.rx_last = 1'b1;
                  next_r.rcnt = '0;
                  if (r.rmode != scn_pkg::MODE_MULTI)
                  begin
                     next_r.rst = scn_pkg::HR_HUNT;
                  end
               end
            end
            default:
            begin
               next_r.rst = scn_pkg::HR_HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESETN_I)
      begin
         r <= scn_pkg::HOST_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign LINK.h2d_data = r.tx_data;
   assign LINK.h2d_valid = r.tx_valid;
   assign LINK.d2h_ready = 1'b1;
   assign REQ_READY_O = (r.tst == scn_pkg::HT_IDLE);
   assign PLD_READY_O = (r.tst == scn_pkg::HT_PLD) && free;
   assign DESC_VALID_O = r.desc_valid;
   assign DESC_LEN_O = r.rlen;
   assign DESC_MODE_O = r.rmode;
   assign DESC_TYPE_O = r.dtype;
   assign RX_VALID_O = r.rx_valid;
   assign RX_BYTE_O = r.rx_byte;
   assign RX_LAST_O = r.rx_last;
endmodule

// *** tb/scn_link_asserts.sv ***
// Purpose: Link checks
// Assumes: Data and type bytes below 80h
// Notes: Watches the byte link only
`timescale 1ns/100ps
module scn_link_asserts (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);
   logic seen, tx;
   logic [7:0] prev;
   logic [2:0] pos;
   wire hs = d2h_valid && d2h_ready;
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESETN_I)
      begin
         seen <= 1'b0;
         tx <= 1'b0;
         prev <= 8'h00;
         pos <= 3'h0;
      end
      else
      begin
         seen <= seen || (h2d_valid && h2d_ready);
         tx <= tx || hs;
         if (hs)
         begin
            prev <= d2h_data;
            pos <= (d2h_data == 8'h5A && prev == 8'hA5) ? 3'h1 :
               (pos != 3'h0 && pos < 3'h5) ? pos + 3'h1 : 3'h0;
         end
      end
   end
   sequence s_sync;
      hs && d2h_data == 8'h5A && prev == 8'hA5;
   endsequence
   a_quiet_boot: assert property (!seen |-> !d2h_valid)
      else $error("early output");
   a_req_start: assert property ($rose(h2d_valid) |-> h2d_data == 8'hA5)
      else $error("bad start");
   a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
      else $error("stall dropped");
   a_first_sync: assert property (hs && !tx |-> d2h_data == 8'hA5)
      else $error("bad sync1");
   a_sync_next: assert property (hs && !tx |-> ##[1:3] (hs && d2h_data == 8'h5A))
      else $error("bad sync2");
   a_mode_legal: assert property (hs && pos == 3'h4 |-> !d2h_data[7])
      else $error("bad mode");
   a_desc_done: assert property (s_sync |-> ##[1:20] (hs && pos == 3'h5))
      else $error("short descriptor");
   a_desc_pace: assert property (hs && pos != 3'h0 && pos < 3'h5 |-> ##[1:3] hs)
      else $error("descriptor gap");
endmodule

// *** tb/testbench.sv ***
// Purpose: Both ends joined, random sessions
// Assumes: Short wait parameters
// Notes: Data bytes kept below 80h
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic req_v = 1'b0;
   logic rsp_s = 1'b0;
   logic rsp_n = 1'b0;
   logic none = 1'b0;
   logic dv = 1'b1;
   logic [7:0] d = 8'h11;
   logic [7:0] cmd = 8'h00;
   logic [7:0] cnt = 8'h00;
   logic [29:0] len = 30'h1;
   logic [1:0] mode = 2'h0;
   logic [7:0] typ = 8'h00;
   logic [7:0] pl [32];
   logic [7:0] dq [$];
   logic cv, pv, er, dr, act, rr, pr, ds, rv, rl;
   logic [7:0] cc, pc, pb, dt, rb;
   logic [29:0] dl;
   logic [1:0] dm;
   integer seed = 32'hB8C6CBE8;
   int fail_count = 0;
   int cmp_count = 0;
   int ncmd = 0, ndesc = 0, pi = 0, dk = 0, ps = 0, stall = 0, rxk = 0, n0;
   scn_link_if lk ();
   scn_device #(.TIMEOUT_CYCLES(2000)) i_scn_device (.CORE_CLK_I(clk),
      .RESETN_I(resetn), .LINK(lk), .CMD_VALID_O(cv), .CMD_CODE_O(cc), .PLD_COUNT_O(pc),
      .PLD_VALID_O(pv), .PLD_BYTE_O(pb), .REQ_ERR_O(er), .RSP_START_I(rsp_s),
      .RSP_NONE_I(rsp_n), .RSP_LEN_I(len), .RSP_MODE_I(mode), .RSP_TYPE_I(typ),
      .DATA_VALID_I(dv), .DATA_BYTE_I(d), .DATA_READY_O(dr), .SCAN_ACTIVE_O(act));
   scn_host #(.STOP_GAP(20), .RESET_GAP(40), .REPLY_WAIT(200)) i_scn_host (.CORE_CLK_I(clk),
      .RESETN_I(resetn), .LINK(lk), .REQ_VALID_I(req_v), .REQ_READY_O(rr), .REQ_CMD_I(cmd),
      .REQ_COUNT_I(cnt), .PLD_VALID_I(1'b1), .PLD_BYTE_I(pl[pi]), .PLD_READY_O(pr),
      .DESC_VALID_O(ds), .DESC_LEN_O(dl), .DESC_MODE_O(dm), .DESC_TYPE_O(dt),
      .RX_VALID_O(rv), .RX_BYTE_O(rb), .RX_LAST_O(rl));
   scn_link_asserts i_scn_link_asserts (.CORE_CLK_I(clk), .RESETN_I(resetn),
      .h2d_data(lk.h2d_data), .h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready),
      .d2h_data(lk.d2h_data), .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic req(input logic [7:0] c, input logic [7:0] n);
      for (int k = 0; k < 32; k++)
         pl[k] = 8'($random(seed));
      pi = 0;
      dk = 0;
      cmd = c;
      cnt = n;
      req_v = 1'b1;
      do @(posedge clk); while (!rr);
      #1 req_v = 1'b0;
      w(300);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      if (ds)
      begin
         chk("len", dl, len);
         chk("mode", dm, {1'b0, mode[0]});
         chk("type", dt, typ);
         ndesc++;
         rxk = 0;
      end
      if (rv)
      begin
         chk("rx", rb, dq.pop_front());
         chk("last", rl, rxk % len == len - 1);
         rxk++;
      end
      if (pv)
      begin
         chk("pld", pb, pl[dk]);
         dk++;
      end
      if (er)
         chk("err", er, 1'b0);
      if (pr)
         pi <= pi + 1;
   end
   always @(posedge clk)
   begin
      if (cv)
      begin
         chk("cmd", cc, cmd);
         chk("cnt", pc, cnt);
         ncmd++;
         #1 rsp_s = !none;
         rsp_n = none;
         w(1);
         rsp_s = 1'b0;
         rsp_n = 1'b0;
      end
   end
   always @(posedge clk)
   begin
      if (dv && dr)
      begin
         dq.push_back(d);
         ps++;
         #1 d = 8'($random(seed)) & 8'h7F;
         if (ps == stall)
            dv = 1'b0;
      end
   end
   initial
   begin
      #100000;
      fail_count++;
      test_done;
   end
   initial
   begin
      w(4);
      resetn = 1'b1;
      for (int j = 0; j < 4; j++)
      begin
         n0 = ndesc;
         len = 30'(1 + {$random(seed)} % 4);
         mode = 2'($random(seed)) & 2'h2;
         typ = 8'($random(seed)) & 8'h7F;
         req(8'h50 | (8'($random(seed)) & 8'h0F), 8'h00);
         chk("desc", ndesc, n0 + 1);
      end
      none = 1'b1;
      req(8'h25, 8'h00);
      chk("stop", ndesc, n0 + 1);
      chk("ncmd", ncmd, 5);
      none = 1'b0;
      len = 30'h2;
      mode = 2'h1;
      ps = 0;
      stall = 5;
      req(8'h20, 8'h00);
      chk("act", act, 1'b1);
      chk("sent", ps, 5);
      none = 1'b1;
      req(8'h82, 8'h14);
      chk("hold", act, 1'b1);
      stall = 0;
      dv = 1'b1;
      w(300);
      chk("exit", act, 1'b0);
      chk("cached", ncmd, 7);
      chk("plds", dk, 20);
      test_done;
   end
endmodule
